// ---- rtl/ict_pkg.sv ----
/*
 * Shared types and constants of the channel instruction executor: operation codes, the
 * request and result carriers, execution clock counts and encoded length ranges.
 * Assumes one clk cycle stands for one processor clock period.
 */
package ict_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int TP_W  = 20;
    localparam int CNT_W = 6;

    // ************************************************************
    // Operations
    // ************************************************************
    typedef enum logic [3:0] {
        op_and_word_variable      = 4'h0,
        op_and_byte_variable      = 4'h1,
        op_and_byte_immediate     = 4'h2,
        op_branch_if_bit_set      = 4'h3,
        op_branch_if_bit_clear    = 4'h4,
        op_branch_if_word_nonzero = 4'h5,
        op_branch_if_byte_nonzero = 4'h6,
        op_branch_if_word_zero    = 4'h7,
        op_branch_on_masked_mismatch = 4'h8
    } ict_op_e;

    // ************************************************************
    // Execution clock counts
    // ************************************************************
    localparam logic [CNT_W-1:0] CLK_AND_W_REG_EVEN = 6'h0b;  // 11
    localparam logic [CNT_W-1:0] CLK_AND_W_REG_ODD  = 6'h0f;  // 15
    localparam logic [CNT_W-1:0] CLK_AND_W_MEM_EVEN = 6'h10;  // 16
    localparam logic [CNT_W-1:0] CLK_AND_W_MEM_ODD  = 6'h1a;  // 26
    localparam logic [CNT_W-1:0] CLK_AND_B_REG      = 6'h0b;  // 11
    localparam logic [CNT_W-1:0] CLK_AND_B_MEM      = 6'h10;  // 16
    localparam logic [CNT_W-1:0] CLK_AND_BI_REG     = 6'h03;  // 3
    localparam logic [CNT_W-1:0] CLK_AND_BI_MEM     = 6'h10;  // 16
    localparam logic [CNT_W-1:0] CLK_BIT_TEST       = 6'h0e;  // 14
    localparam logic [CNT_W-1:0] CLK_MASKED         = 6'h0e;  // 14
    localparam logic [CNT_W-1:0] CLK_ZT_REG         = 6'h05;  // 5
    localparam logic [CNT_W-1:0] CLK_ZT_MEM_EVEN    = 6'h0c;  // 12
    localparam logic [CNT_W-1:0] CLK_ZT_MEM_ODD     = 6'h10;  // 16
    localparam logic [CNT_W-1:0] CLK_ZT_BYTE        = 6'h0c;  // 12

    // ************************************************************
    // Encoded length ranges in bytes
    // ************************************************************
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_3 = 3'h3;
    localparam logic [2:0] LEN_4 = 3'h4;
    localparam logic [2:0] LEN_5 = 3'h5;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        ict_op_e         op;        // Operation
        logic            mem_opnd;  // Memory operand is destination (AND) or source (branch)
        logic            aligned;   // Word at even address on 16-bit bus, or 8-bit bus
        logic [2:0]      len;       // Encoded length in bytes
        logic [2:0]      bit_sel;   // Bit number for bit tests
        logic [7:0]      disp;      // Short branch displacement
        logic [7:0]      imm;       // Immediate byte
        logic [15:0]     reg_val;   // Register operand
        logic [15:0]     mem_val;   // Memory operand
        logic [15:0]     mask_register; // High byte mask, low byte compare value
        logic [TP_W-1:0] task_pointer;  // Address of this instruction
    } ict_req_s;

    typedef struct packed {
        logic [TP_W-1:0] tp_next;   // New task pointer
        logic            taken;     // Branch taken
        logic            wr_reg;    // Write data to the register operand
        logic            wr_mem;    // Write data to the memory operand
        logic [15:0]     data;      // AND result
    } ict_res_s;

endpackage

// ---- rtl/ict_timer.sv ----
/*
 * Execution clock counter: loaded with a clock count, flags the last clock of it.
 * Assumes load only while not busy.
 */
`timescale 1ns/1ps
module ict_timer #(
    parameter int W = 6
) (
    input  wire logic         clk,    // Clock
    input  wire logic         rst,    // Synchronous reset, active high
    input  wire logic         load,   // Start counting
    input  wire logic [W-1:0] count,  // Clocks to run, at least one
    output logic              busy,   // Count in progress
    output logic              last    // Final clock of the count
);
    logic [W-1:0] remain;

    assign busy = (remain != '0);
    assign last = (remain == W'(1));

    always_ff @(posedge clk) begin
        if (rst) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (busy) begin
            remain <= remain - W'(1);
        end
    end
endmodule // ict_timer

// ---- rtl/ict_exec.sv ----
/*
 * Executor for logical AND and short conditional branches of the channel
 * instruction set: computes result and next task pointer, and holds the
 * instruction for its documented clock count.
 * Assumes the request is already decoded and its operands fetched; operand
 * fetch and write-back belong to the surrounding bus logic.
 */
`timescale 1ns/1ps

// Summary of operation
// - Word AND takes 11/15 or 16/26 clocks
// - Byte AND takes 11 or 16 clocks
// - Immediate byte AND takes 3 or 16
// - Bit-set branch tests memory bit, 14 clocks
// - Bit-clear branch on zero bit, 14 clocks
// - Word-nonzero branch, register source 5 clocks, memory 12/16
// - Byte-nonzero branch on memory byte, 12 clocks
// - Word-zero branch, 5 or 12/16 clocks
// - Masked mismatch branch compares under mask, 14
// - First figure aligned word, second otherwise
// - Pointer advances by length or displacement
// - Displacement signed, from instruction end
module ict_exec (
    input  wire logic             clk,    // Clock
    input  wire logic             rst,    // Synchronous reset, active high
    input  wire logic             start,  // Request valid
    input  wire ict_pkg::ict_req_s req,   // Decoded instruction with operands
    output logic                  ready,  // Request can be taken
    output logic                  done,   // Last clock of execution
    output logic                  err,    // Illegal request refused
    output ict_pkg::ict_res_s     res     // Result, valid from done on
);
    import ict_pkg::*;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic [CNT_W-1:0] ict_clocks(ict_op_e op, logic mem, logic al);
        unique case (op)
            op_and_word_variable: begin
                if (mem) return al ? CLK_AND_W_MEM_EVEN : CLK_AND_W_MEM_ODD;
                else     return al ? CLK_AND_W_REG_EVEN : CLK_AND_W_REG_ODD;
            end
            op_and_byte_variable:   return mem ? CLK_AND_B_MEM : CLK_AND_B_REG;
            op_and_byte_immediate:  return mem ? CLK_AND_BI_MEM : CLK_AND_BI_REG;
            op_branch_if_bit_set,
            op_branch_if_bit_clear: return CLK_BIT_TEST;
            op_branch_if_byte_nonzero: return CLK_ZT_BYTE;
            op_branch_if_word_nonzero,
            op_branch_if_word_zero: begin
                if (mem) return al ? CLK_ZT_MEM_EVEN : CLK_ZT_MEM_ODD;
                else     return CLK_ZT_REG;
            end
            op_branch_on_masked_mismatch: return CLK_MASKED;
            default: return CLK_ZT_REG;
        endcase
    endfunction

    // Length window per form; also rejects byte tests on a register source
    function automatic logic ict_legal(ict_op_e op, logic mem, logic [2:0] len);
        unique case (op)
            op_and_word_variable,
            op_and_byte_variable:  return len >= LEN_2 && len <= LEN_3;
            op_and_byte_immediate: return mem ? (len >= LEN_3 && len <= LEN_4) : (len == LEN_3);
            op_branch_if_word_nonzero,
            op_branch_if_word_zero:
                return mem ? (len >= LEN_3 && len <= LEN_5) : (len >= LEN_3 && len <= LEN_4);
            op_branch_if_bit_set,
            op_branch_if_bit_clear,
            op_branch_if_byte_nonzero,
            op_branch_on_masked_mismatch: return mem && len >= LEN_3 && len <= LEN_5;
            default: return 1'b0;
        endcase
    endfunction

    // ************************************************************
    // Operand evaluation
    // ************************************************************
    wire logic            is_and   = (req.op == op_and_word_variable)
                                   || (req.op == op_and_byte_variable)
                                   || (req.op == op_and_byte_immediate);
    wire logic            legal    = ict_legal(req.op, req.mem_opnd, req.len);
    wire logic            accept   = start && ready && legal;
    wire logic [7:0]      dst_byte = req.mem_opnd ? req.mem_val[7:0] : req.reg_val[7:0];
    wire logic [7:0]      src_byte = (req.op == op_and_byte_immediate) ? req.imm
                                   : (req.mem_opnd ? req.reg_val[7:0] : req.mem_val[7:0]);
    wire logic [7:0]      and_byte = dst_byte & src_byte;
    // Byte result into a register fills bits 8-15 with its bit 7
    wire logic [15:0]     byte_out = req.mem_opnd ? {8'h00, and_byte}
                                                  : {{8{and_byte[7]}}, and_byte};
    wire logic [15:0]     and_data = (req.op == op_and_word_variable)
                                   ? (req.reg_val & req.mem_val) : byte_out;
    wire logic [15:0]     word_src = req.mem_opnd ? req.mem_val : req.reg_val;
    wire logic            bit_hit  = req.mem_val[req.bit_sel];
    wire logic            mismatch = |((req.mem_val[7:0] ^ req.mask_register[7:0])
                                       & req.mask_register[15:8]);
    wire logic            taken    =
        ((req.op == op_branch_if_bit_set)         &&  bit_hit)
     || ((req.op == op_branch_if_bit_clear)       && !bit_hit)
     || ((req.op == op_branch_if_word_nonzero)    && (word_src != 16'h0000))
     || ((req.op == op_branch_if_byte_nonzero)    && (req.mem_val[7:0] != 8'h00))
     || ((req.op == op_branch_if_word_zero)       && (word_src == 16'h0000))
     || ((req.op == op_branch_on_masked_mismatch) &&  mismatch);
    wire logic [TP_W-1:0] tp_seq   = req.task_pointer + TP_W'(req.len);
    // Offset counts from the end of the branch, so it adds to tp_seq
    wire logic [TP_W-1:0] tp_jump  = tp_seq + {{(TP_W-8){req.disp[7]}}, req.disp};
    wire logic [CNT_W-1:0] clocks  = ict_clocks(req.op, req.mem_opnd, req.aligned);

    ict_res_s next_res;
    assign next_res.tp_next = taken ? tp_jump : tp_seq;
    assign next_res.taken   = taken;
    // Untaken branches and all branches write nothing
    assign next_res.wr_reg  = is_and && !req.mem_opnd;
    assign next_res.wr_mem  = is_and && req.mem_opnd;
    assign next_res.data    = is_and ? and_data : 16'h0000;

    // ************************************************************
    // Sequencing
    // ************************************************************
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_run  = 2'b10
    } ict_state_e;

    ict_state_e state;
    ict_state_e next_state;
    logic       last;

    ict_timer #(.W(CNT_W)) u_timer (
        .clk   (clk),
        .rst   (rst),
        .load  (accept),
        .count (clocks),
        .busy  (),
        .last  (last)
    );

    assign ready = (state == st_idle);
    assign done  = (state == st_run) && last;

    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: if (accept) next_state = st_run;
            st_run:  if (last)   next_state = st_idle;
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= st_idle;
            err   <= 1'b0;
            res   <= '0;
        end else begin
            state <= next_state;
            err   <= start && ready && !legal;
            if (accept) res <= next_res;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [TP_W-1:0] exp_seq;
    logic [7:0]      exp_disp;
    logic            exp_branch;
    always_ff @(posedge clk) begin
        if (rst) begin
            exp_seq    <= '0;
            exp_disp   <= 8'h00;
            exp_branch <= 1'b0;
        end else if (accept) begin
            exp_seq    <= req.task_pointer + TP_W'(req.len);
            exp_disp   <= req.disp;
            exp_branch <= !is_and;
        end
    end

    and_word_time_a: assert property (
        accept && req.op == op_and_word_variable && !req.mem_opnd && req.aligned
        |-> ##11 done) else $error("word AND time");
    and_byte_time_a: assert property (
        accept && req.op == op_and_byte_variable && req.mem_opnd
        |-> ##16 done) else $error("byte AND time");
    and_byte_reg_a: assert property (
        accept && req.op == op_and_byte_variable && !req.mem_opnd
        |-> ##11 done) else $error("byte AND register time");
    and_imm_time_a: assert property (
        accept && req.op == op_and_byte_immediate && !req.mem_opnd
        |-> !done ##1 !done ##1 !done ##1 done) else $error("immediate AND time");
    imm_mem_time_a: assert property (
        accept && req.op == op_and_byte_immediate && req.mem_opnd
        |-> ##16 done) else $error("immediate AND memory time");
    bit_set_a: assert property (
        accept && req.op == op_branch_if_bit_set
        |-> ##14 done && res.taken == $past(bit_hit, 14)) else $error("bit set branch");
    bit_clear_a: assert property (
        accept && req.op == op_branch_if_bit_clear
        |-> ##14 done && res.taken != $past(bit_hit, 14)) else $error("bit clear branch");
    nonzero_reg_a: assert property (
        accept && req.op == op_branch_if_word_nonzero && !req.mem_opnd
        |-> ##5 done) else $error("nonzero time");
    byte_nz_a: assert property (
        accept && req.op == op_branch_if_byte_nonzero
        |-> ##12 done) else $error("byte nonzero time");
    word_zero_a: assert property (
        accept && req.op == op_branch_if_word_zero && req.mem_opnd && !req.aligned
        |-> ##16 done) else $error("word zero time");
    zero_reg_a: assert property (
        accept && req.op == op_branch_if_word_zero && !req.mem_opnd
        |-> ##5 done) else $error("word zero register time");
    masked_cmp_a: assert property (
        accept && req.op == op_branch_on_masked_mismatch
        |-> ##14 done && res.taken == $past(mismatch, 14)) else $error("masked branch");
    odd_word_a: assert property (
        accept && req.op == op_and_word_variable && req.mem_opnd && !req.aligned
        |-> ##26 done) else $error("odd word time");
    seq_tp_a: assert property (
        done && !res.taken
        |-> res.tp_next == exp_seq) else $error("sequential pointer");
    jump_tp_a: assert property (
        done && res.taken
        |-> res.tp_next == exp_seq + {{(TP_W-8){exp_disp[7]}}, exp_disp})
        else $error("branch pointer");
    no_write_a: assert property (
        done && exp_branch && !res.taken
        |-> !res.wr_reg && !res.wr_mem && res.data == 16'h0000)
        else $error("untaken writes");
endmodule // ict_exec

// ---- bench/ict_mem_model.sv ----
/*
 * Behavioural model of the system memory seen by the executor: a small byte store
 * that hands back the operand word at a byte address, low byte first.
 * Assumes the bench writes operands through put before presenting a request.
 */
`timescale 1ns/1ps
module ict_mem_model (
    input  wire logic [19:0] addr,   // Byte address of operand
    output logic      [15:0] rdata   // Word at addr, low byte first
);
    logic [7:0] cells [0:255];

    // ************************************************************
    // Read port
    // ************************************************************
    // Only 256 bytes kept; the address wraps inside that window
    assign rdata = {cells[8'(addr + 20'h0_0001)], cells[addr[7:0]]};

    task automatic put(input logic [19:0] a, input logic [15:0] w);
        cells[a[7:0]] = w[7:0];
        cells[8'(a + 20'h0_0001)] = w[15:8];
    endtask
endmodule // ict_mem_model

// ---- bench/ict_exec_test.sv ----
/*
 * Self-checking bench of the channel instruction executor: clock counts, AND results,
 * branch decisions and task pointer updates, and refusal of illegal requests.
 * Assumes ict_pkg, ict_exec and ict_mem_model are compiled before it.
 */
`timescale 1ns/1ps
module ict_exec_test;
    import ict_pkg::*;
    logic        clk, rst, start, ready, done, err;
    ict_req_s    req;
    ict_res_s    res;
    logic [19:0] maddr;
    logic [15:0] mword;
    int          fail_count = 0;
    int          num_checks = 0;

    ict_exec uut (.clk(clk), .rst(rst), .start(start), .req(req), .ready(ready),
                  .done(done), .err(err), .res(res));
    ict_mem_model mem (.addr(maddr), .rdata(mword));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ************************************************************
    // Report and compare
    // ************************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_b(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %0b seen %0b", nm, e, g);
        end
    endtask

    task automatic chk_v(input string nm, input logic [19:0] e, input logic [19:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // ************************************************************
    // One request from accept to done
    // ************************************************************
    task automatic run(input ict_op_e op, input logic mo, al, input logic [2:0] ln,
                       input logic [15:0] m, input logic [5:0] n, input logic tk,
                       input logic [15:0] dat);
        int          c;
        logic [19:0] tp;
        logic        is_and;
        is_and = (op == op_and_word_variable) || (op == op_and_byte_variable)
              || (op == op_and_byte_immediate);
        tp = req.task_pointer + 20'(ln) + (tk ? {{12{req.disp[7]}}, req.disp} : 20'h0_0000);
        mem.put(maddr, m);
        // Model read port settles before its word is sampled
        @(negedge clk);
        req.op = op;
        req.mem_opnd = mo;
        req.aligned = al;
        req.len = ln;
        req.mem_val = mword;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        c = 1;
        while (done !== 1'b1 && c < 60) begin
            @(negedge clk);
            c++;
        end
        if (c >= 60) begin
            fail_count++;
            test_done();
        end
        chk_v("clocks", 20'(n), 20'(c));
        chk_b("taken", tk, res.taken);
        chk_v("tp_next", tp, res.tp_next);
        chk_v("data", 20'(dat), 20'(res.data));
        chk_b("wr_reg", is_and & ~mo, res.wr_reg);
        chk_b("wr_mem", is_and & mo, res.wr_mem);
        @(negedge clk);
        chk_b("ready", 1'b1, ready);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        chk_b("ready", 1'b1, ready);
        chk_b("done", 1'b0, done);
        chk_b("err", 1'b0, err);
        chk_v("tp_next", 20'h0_0000, res.tp_next);
    endtask

    // Reset in mid-execution drops the request and clears the result
    task automatic t_reset_mid();
        logic seen;
        seen = 1'b0;
        req.op = op_and_word_variable;
        req.mem_opnd = 1'b1;
        req.aligned = 1'b0;
        req.len = 3'h2;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (5) @(negedge clk);
        chk_b("ready", 1'b0, ready);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset();
        for (int i = 0; i < 30; i++) begin
            if (done !== 1'b0) seen = 1'b1;
            @(negedge clk);
        end
        chk_b("done", 1'b0, seen);
    endtask

    task automatic t_and();
        req.reg_val = 16'hf0f3;
        req.imm = 8'ha7;
        run(op_and_word_variable, 0, 1, 3'h2, 16'h3c9e, 6'h0b, 0, 16'h3092);
        run(op_and_word_variable, 0, 0, 3'h3, 16'h3c9e, 6'h0f, 0, 16'h3092);
        run(op_and_word_variable, 1, 1, 3'h3, 16'h3c9e, 6'h10, 0, 16'h3092);
        run(op_and_word_variable, 1, 0, 3'h2, 16'h3c9e, 6'h1a, 0, 16'h3092);
        run(op_and_byte_variable, 0, 1, 3'h2, 16'h3c9e, 6'h0b, 0, 16'hff92);
        run(op_and_byte_variable, 1, 1, 3'h3, 16'h3c9e, 6'h10, 0, 16'h0092);
        run(op_and_byte_immediate, 0, 1, 3'h3, 16'h3c9e, 6'h03, 0, 16'hffa3);
        run(op_and_byte_immediate, 1, 1, 3'h4, 16'h3c9e, 6'h10, 0, 16'h0086);
    endtask

    task automatic t_branch();
        req.disp = 8'h80;
        req.bit_sel = 3'h7;
        run(op_branch_if_bit_set, 1, 1, 3'h3, 16'h0080, 6'h0e, 1, 16'h0000);
        req.bit_sel = 3'h0;
        run(op_branch_if_bit_set, 1, 1, 3'h5, 16'h00fe, 6'h0e, 0, 16'h0000);
        req.disp = 8'h7f;
        req.bit_sel = 3'h3;
        run(op_branch_if_bit_clear, 1, 1, 3'h3, 16'h00f7, 6'h0e, 1, 16'h0000);
        run(op_branch_if_bit_clear, 1, 1, 3'h4, 16'h0008, 6'h0e, 0, 16'h0000);
        req.reg_val = 16'h0100;
        run(op_branch_if_word_nonzero, 0, 1, 3'h3, 16'h0000, 6'h05, 1, 16'h0000);
        req.reg_val = 16'h0000;
        run(op_branch_if_word_nonzero, 0, 1, 3'h4, 16'hffff, 6'h05, 0, 16'h0000);
        run(op_branch_if_word_nonzero, 1, 0, 3'h5, 16'h0100, 6'h10, 1, 16'h0000);
        run(op_branch_if_byte_nonzero, 1, 1, 3'h3, 16'h0100, 6'h0c, 0, 16'h0000);
        run(op_branch_if_byte_nonzero, 1, 1, 3'h5, 16'h0001, 6'h0c, 1, 16'h0000);
        run(op_branch_if_word_zero, 0, 1, 3'h3, 16'h1234, 6'h05, 1, 16'h0000);
        run(op_branch_if_word_zero, 1, 1, 3'h3, 16'h0000, 6'h0c, 1, 16'h0000);
        run(op_branch_if_word_zero, 1, 0, 3'h5, 16'h0100, 6'h10, 0, 16'h0000);
        req.mask_register = 16'h0f05;
        run(op_branch_on_masked_mismatch, 1, 1, 3'h3, 16'h00a5, 6'h0e, 0, 16'h0000);
        run(op_branch_on_masked_mismatch, 1, 1, 3'h5, 16'h00a4, 6'h0e, 1, 16'h0000);
    endtask

    // Illegal code, then a length outside its form's range
    task automatic t_refuse();
        logic [19:0] keep;
        keep = res.tp_next;
        req.op = ict_op_e'(4'h9);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk_b("err", 1'b1, err);
        chk_b("ready", 1'b1, ready);
        chk_v("tp_next", keep, res.tp_next);
        @(negedge clk);
        chk_b("err", 1'b0, err);
        req.op = op_and_byte_immediate;
        req.mem_opnd = 1'b0;
        req.len = 3'h4;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk_b("err", 1'b1, err);
        chk_v("tp_next", keep, res.tp_next);
    endtask

    initial begin
        rst = 1'b1;
        start = 1'b0;
        req = '0;
        req.task_pointer = 20'h0_0100;
        maddr = 20'h0_0200;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_and();
        t_reset_mid();
        t_branch();
        t_refuse();
        test_done();
    end
endmodule // ict_exec_test
